// file: underpower_params.svh
// Constants of the underpower protection stage
`ifndef UNDERPOWER_PARAMS_SVH
`define UNDERPOWER_PARAMS_SVH
`define MCLK_HZ 25000000
`define TIME_BASE_MS 5
`define TICK_CYCLES ((`MCLK_HZ / 1000) * `TIME_BASE_MS)
`define PRE_TRIG_MS 20
`define PRE_TRIG_TICKS (`PRE_TRIG_MS / `TIME_BASE_MS)
`define PRE_FAULT_MS 200
`define PRE_FAULT_TICKS (`PRE_FAULT_MS / `TIME_BASE_MS)
`define RESET_RATIO_PCT 40'd103
`define PCT_FULL 40'd100
`define RATIO_MAX 16'hFFFF
`define NUM_RECORDS 12
`define NUM_GROUPS 8
`define REG_CTRL 8'h00
`define REG_GROUP 8'h04
`define REG_PSET 8'h08
`define REG_LPBSET 8'h0C
`define REG_OPDLY 8'h10
`define REG_RSDLY 8'h14
`define REG_STATUS 8'h18
`define REG_IRQ_CLR 8'h1C
`define REG_IRQ_EN 8'h20
`define REG_CNT_CLR 8'h24
`define REG_CNT_START 8'h28
`define REG_CNT_TRIP 8'h2C
`define REG_CNT_BLK 8'h30
`define REG_INFO 8'h34
`define REG_TIMES 8'h38
`define REG_REC_SEL 8'h3C
`define REG_REC_TIME 8'h40
`define REG_REC_INFO 8'h44
`define REG_REC_PRE 8'h48
`define REG_REC_FLT 8'h4C
`define REG_REC_PF 8'h50
`define REG_REC_PTR 8'h54
`define CTRL_MODE_LSB 0
`define CTRL_FORCE_EN 3
`define CTRL_FORCE_LSB 4
`define CTRL_EVT_ON 6
`define CTRL_EVT_OFF 7
`define CTRL_LPI_EN 8
`define CTRL_RST 32'h000000C0
`define PSET_RST 32'h00002710
`define LPBSET_RST 32'h00001388
`define OPDLY_RST 16'h0014
`define RSDLY_RST 16'h0000
`define MODE_ON 3'h0
`define MODE_BLOCKED 3'h1
`define MODE_TEST 3'h2
`define MODE_TEST_BLOCKED 3'h3
`define MODE_OFF 3'h4
`endif

// file: underpower_pkg.sv
// Types of the underpower protection stage
package underpower_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_HOLD, ST_TRIP, ST_BLK} stage_state_e;
    typedef logic [2:0] mode_t;
    typedef logic [1:0] cond_t;
    typedef logic [31:0] power_t;
endpackage

// file: underpower_protection_stage.sv
// Underpower protection stage with register port, events and fault records
//
// Behaviour
// - Active power from phase currents and voltages per 5 ms
// - Compare measured power with pick-up setting
// - Release above 103 % of setting, or by low power inhibit or mode Off
// - Low power inhibit until power above 1.03 setting
// - Setting groups switchable while running
// - Mode and forcing untouched by group change
// - Block sampled each 5 ms time base; start when unblocked
// - Blocked pick-up gives blocked, no timing
// - Late block drops start, release timing follows
// - Definite-time trip and reset delays only
// - ON/OFF events, time-stamped, selectable storage
// - Clearable counters for start, trip, blocked
// - Exactly one stage
// - Twelve fault records on ON events
// - Mode On, Blocked, Test, Test/Blocked, Off
// - Forced condition Normal, Start, Trip, Blocked
// - Report times in 5 ms, ratio in 0.01
`include "underpower_params.svh"
module underpower_protection_stage #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [14:0] phase_a_current_fundamental,
    input wire logic [14:0] phase_b_current_fundamental,
    input wire logic [14:0] phase_c_current_fundamental,
    input wire logic [14:0] voltage_ch1_fundamental,
    input wire logic [14:0] voltage_ch2_fundamental,
    input wire logic [14:0] voltage_ch3_fundamental,
    input wire logic block_in,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic start_o,
    output logic trip_o,
    output logic blocked_o,
    output logic [1:0] cond_o,
    output logic irq_o,
    output logic evt_valid_o,
    output logic [2:0] evt_code_o,
    output logic [31:0] evt_time_o
);
    // Time base divider
    logic [16:0] div_r;
    logic tick_r, proc_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (div_r == 17'(TICK_CYCLES - 1));
            div_r <= (div_r == 17'(TICK_CYCLES - 1)) ? '0 : div_r + 17'h1;
        end
    end

    // Registers
    logic [31:0] ctrl_r, pset_g [`NUM_GROUPS], lpb_g [`NUM_GROUPS];
    logic [15:0] opd_g [`NUM_GROUPS], rsd_g [`NUM_GROUPS];
    logic [2:0] act_grp_r, edit_grp_r;
    logic [5:0] sts_r, en_r;
    logic [3:0] rec_sel_r;
    wire w_ctrl = wr && addr == `REG_CTRL;
    wire w_grp = wr && addr == `REG_GROUP;
    wire w_clr = wr && addr == `REG_IRQ_CLR;
    wire w_cclr = wr && addr == `REG_CNT_CLR;
    wire [2:0] mode = ctrl_r[`CTRL_MODE_LSB +: 3];
    wire force_en = ctrl_r[`CTRL_FORCE_EN];
    wire [1:0] force_sel = ctrl_r[`CTRL_FORCE_LSB +: 2];
    wire [31:0] pset = pset_g[act_grp_r];
    wire [31:0] lpbset = lpb_g[act_grp_r];
    wire [15:0] opd = opd_g[act_grp_r];
    wire [15:0] rsd = rsd_g[act_grp_r];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= `CTRL_RST;
            act_grp_r <= '0;
            edit_grp_r <= '0;
            en_r <= '0;
            rec_sel_r <= '0;
        end else begin
            if (w_ctrl) ctrl_r <= wdata;
            if (w_grp) begin
                act_grp_r <= wdata[2:0];
                edit_grp_r <= wdata[6:4];
            end
            if (wr && addr == `REG_IRQ_EN) en_r <= wdata[5:0];
            if (wr && addr == `REG_REC_SEL) rec_sel_r <= wdata[3:0];
        end
    end

    genvar g;
    generate
        for (g = 0; g < `NUM_GROUPS; g++) begin : grp
            wire sel = edit_grp_r == 3'(g);
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    pset_g[g] <= `PSET_RST;
                    lpb_g[g] <= `LPBSET_RST;
                    opd_g[g] <= `OPDLY_RST;
                    rsd_g[g] <= `RSDLY_RST;
                end else if (wr && sel) begin
                    if (addr == `REG_PSET) pset_g[g] <= wdata;
                    if (addr == `REG_LPBSET) lpb_g[g] <= wdata;
                    if (addr == `REG_OPDLY) opd_g[g] <= wdata[15:0];
                    if (addr == `REG_RSDLY) rsd_g[g] <= wdata[15:0];
                end
            end
        end
    endgenerate

    // Power sampling on the time base
    wire [29:0] pa = phase_a_current_fundamental * voltage_ch1_fundamental;
    wire [29:0] pb = phase_b_current_fundamental * voltage_ch2_fundamental;
    wire [29:0] pc = phase_c_current_fundamental * voltage_ch3_fundamental;
    wire [31:0] psum = 32'(pa) + 32'(pb) + 32'(pc);
    underpower_pkg::power_t p_r;
    underpower_pkg::power_t hist [64];
    logic [5:0] hptr_r;
    logic blk_in_r;
    logic [31:0] tstamp_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            p_r <= '0;
            blk_in_r <= 1'b0;
            hptr_r <= '0;
            tstamp_r <= '0;
            proc_r <= 1'b0;
        end else begin
            proc_r <= tick_r;
            if (tick_r) begin
                p_r <= psum;
                blk_in_r <= block_in;
                hptr_r <= hptr_r + 6'h1;
                tstamp_r <= tstamp_r + 32'h1;
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (tick_r) hist[hptr_r] <= psum;
    end

    // Pick-up with hysteresis and low power inhibit
    logic pick_r, lpi_r;
    wire lt_set = p_r < pset;
    wire rel_hi = 40'(p_r) * `PCT_FULL > 40'(pset) * `RESET_RATIO_PCT;
    wire lpi_en = ctrl_r[`CTRL_LPI_EN];
    wire lpi_nxt = lpi_en && (rel_hi ? 1'b0 : (lpi_r || p_r < lpbset));
    wire pick_nxt = !lpi_nxt && (pick_r ? !rel_hi : lt_set);
    wire blk_eff = blk_in_r || mode == `MODE_BLOCKED || mode == `MODE_TEST_BLOCKED;
    wire is_off = mode == `MODE_OFF;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pick_r <= 1'b0;
            lpi_r <= 1'b0;
        end else if (proc_r) begin
            pick_r <= pick_nxt && !is_off;
            lpi_r <= lpi_nxt;
        end
    end

    // Stage sequencer
    underpower_pkg::stage_state_e st_r;
    logic [15:0] tmr_r, rel_r;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_r <= underpower_pkg::ST_IDLE;
            tmr_r <= '0;
            rel_r <= '0;
        end else if (proc_r) begin
            if (is_off) begin
                st_r <= underpower_pkg::ST_IDLE;
            end else begin
                unique case (st_r)
                    underpower_pkg::ST_IDLE: begin
                        tmr_r <= opd;
                        if (pick_r && blk_eff) st_r <= underpower_pkg::ST_BLK;
                        else if (pick_r) st_r <= underpower_pkg::ST_RUN;
                    end
                    underpower_pkg::ST_RUN: begin
                        if (!pick_r || blk_eff) begin
                            st_r <= underpower_pkg::ST_HOLD;
                            rel_r <= rsd;
                        end else if (tmr_r == 16'h0) begin
                            st_r <= underpower_pkg::ST_TRIP;
                        end else begin
                            tmr_r <= tmr_r - 16'h1;
                        end
                    end
                    underpower_pkg::ST_HOLD: begin
                        if (pick_r && !blk_eff) st_r <= underpower_pkg::ST_RUN;
                        else if (rel_r == 16'h0) st_r <= underpower_pkg::ST_IDLE;
                        else rel_r <= rel_r - 16'h1;
                    end
                    underpower_pkg::ST_TRIP: begin
                        tmr_r <= '0;
                        if (!pick_r || blk_eff) st_r <= underpower_pkg::ST_IDLE;
                    end
                    underpower_pkg::ST_BLK: begin
                        if (!pick_r || !blk_eff) st_r <= underpower_pkg::ST_IDLE;
                    end
                    default: st_r <= underpower_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // Outputs and events
    wire act_s = st_r == underpower_pkg::ST_RUN || st_r == underpower_pkg::ST_TRIP;
    wire act_t = st_r == underpower_pkg::ST_TRIP;
    wire act_b = st_r == underpower_pkg::ST_BLK;
    wire is_test = mode == `MODE_TEST || mode == `MODE_TEST_BLOCKED;
    logic s_q, t_q, b_q;
    wire [5:0] ev = {!act_b && b_q, act_b && !b_q, !act_t && t_q, act_t && !t_q,
                     !act_s && s_q, act_s && !s_q};
    wire [5:0] ev_sel = ev & {3{ctrl_r[`CTRL_EVT_OFF], ctrl_r[`CTRL_EVT_ON]}};
    wire [1:0] cond_act = act_t ? 2'h2 : act_s ? 2'h1 : act_b ? 2'h3 : 2'h0;
    wire [5:0] sts_nxt = (sts_r & ~(w_clr ? wdata[5:0] : 6'h0)) | ev;
    logic [5:0] pend_r;
    wire [5:0] pend_low = pend_r & (~pend_r + 6'h1);
    wire [2:0] pend_idx = pend_low[0] ? 3'h0 : pend_low[1] ? 3'h1 : pend_low[2] ? 3'h2 :
                          pend_low[3] ? 3'h3 : pend_low[4] ? 3'h4 : 3'h5;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            {s_q, t_q, b_q} <= '0;
            {start_o, trip_o, blocked_o} <= '0;
            cond_o <= '0;
            sts_r <= '0;
            irq_o <= 1'b0;
            pend_r <= '0;
            evt_valid_o <= 1'b0;
            evt_code_o <= '0;
            evt_time_o <= '0;
        end else begin
            {s_q, t_q, b_q} <= {act_s, act_t, act_b};
            start_o <= act_s;
            trip_o <= act_t && !is_test;
            blocked_o <= act_b;
            cond_o <= force_en ? force_sel : cond_act;
            sts_r <= sts_nxt;
            irq_o <= |(sts_nxt & en_r);
            pend_r <= (pend_r & ~pend_low) | ev_sel;
            evt_valid_o <= |pend_r;
            if (|pend_r) begin
                evt_code_o <= pend_idx;
                evt_time_o <= tstamp_r;
            end
        end
    end

    // Cumulative counters
    logic [15:0] cnt [3];
    generate
        for (g = 0; g < 3; g++) begin : ctr
            always_ff @(posedge mclk or negedge nrst) begin
                if (!nrst) cnt[g] <= '0;
                else if (ev[2 * g]) cnt[g] <= cnt[g] + 16'h1;
                else if (w_cclr && wdata[g]) cnt[g] <= '0;
            end
        end
    endgenerate

    // Fault records
    wire rec_ev = ev[0] || ev[2] || ev[4];
    wire [1:0] rec_code = ev[2] ? 2'h1 : ev[4] ? 2'h2 : 2'h0;
    logic [31:0] rec_time [`NUM_RECORDS], rec_pre [`NUM_RECORDS];
    logic [31:0] rec_flt [`NUM_RECORDS], rec_pf [`NUM_RECORDS];
    logic [20:0] rec_info [`NUM_RECORDS];
    logic [3:0] rec_wp_r;
    wire [5:0] pre_idx = hptr_r - 6'd1 - 6'(`PRE_TRIG_TICKS);
    wire [5:0] pf_idx = hptr_r - 6'd1 - 6'(`PRE_FAULT_TICKS);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) rec_wp_r <= '0;
        else if (rec_ev) rec_wp_r <= (rec_wp_r == 4'(`NUM_RECORDS - 1)) ? '0 : rec_wp_r + 4'h1;
    end
    always_ff @(posedge mclk) begin
        if (rec_ev) begin
            rec_time[rec_wp_r] <= tstamp_r;
            rec_info[rec_wp_r] <= {act_grp_r, rec_code, tmr_r};
            rec_pre[rec_wp_r] <= hist[pre_idx];
            rec_flt[rec_wp_r] <= p_r;
            rec_pf[rec_wp_r] <= hist[pf_idx];
        end
    end

    // Read-only information
    logic [15:0] ratio_r;
    wire [39:0] ratio_w = (pset == 32'h0) ? 40'(`RATIO_MAX) : (40'(p_r) * `PCT_FULL) / 40'(pset);
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) ratio_r <= '0;
        else if (proc_r) ratio_r <= (ratio_w > 40'(`RATIO_MAX)) ? `RATIO_MAX : ratio_w[15:0];
    end
    wire [3:0] rs = (rec_sel_r < 4'(`NUM_RECORDS)) ? rec_sel_r : 4'h0;
    wire [15:0] remain = act_s ? tmr_r : 16'h0;

    // Read data mux
    logic [31:0] rd_mux;
    always_comb begin
        unique case (addr)
            `REG_CTRL: rd_mux = ctrl_r;
            `REG_GROUP: rd_mux = {25'h0, edit_grp_r, 1'b0, act_grp_r};
            `REG_PSET: rd_mux = pset_g[edit_grp_r];
            `REG_LPBSET: rd_mux = lpb_g[edit_grp_r];
            `REG_OPDLY: rd_mux = {16'h0, opd_g[edit_grp_r]};
            `REG_RSDLY: rd_mux = {16'h0, rsd_g[edit_grp_r]};
            `REG_STATUS: rd_mux = {26'h0, sts_r};
            `REG_IRQ_EN: rd_mux = {26'h0, en_r};
            `REG_CNT_START: rd_mux = {16'h0, cnt[0]};
            `REG_CNT_TRIP: rd_mux = {16'h0, cnt[1]};
            `REG_CNT_BLK: rd_mux = {16'h0, cnt[2]};
            `REG_INFO: rd_mux = {ratio_r, 8'h0, lpi_r, pick_r, cond_o, 1'b0, mode};
            `REG_TIMES: rd_mux = {remain, opd};
            `REG_REC_SEL: rd_mux = {28'h0, rec_sel_r};
            `REG_REC_TIME: rd_mux = rec_time[rs];
            `REG_REC_INFO: rd_mux = {11'h0, rec_info[rs]};
            `REG_REC_PRE: rd_mux = rec_pre[rs];
            `REG_REC_FLT: rd_mux = rec_flt[rs];
            `REG_REC_PF: rd_mux = rec_pf[rs];
            `REG_REC_PTR: rd_mux = {28'h0, rec_wp_r};
            default: rd_mux = 32'h0;
        endcase
    end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) rdata <= '0;
        else rdata <= rd ? rd_mux : 32'h0;
    end

    // Checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    chk_sample_power: assert property (tick_r |=> p_r == $past(psum))
        else $error("power not sampled on time base");
    chk_pick_ratio: assert property (proc_r && !pick_r && !lt_set |=> !pick_r)
        else $error("pick-up without power below setting");
    chk_release_hyst: assert property (proc_r && pick_r && !rel_hi && !lpi_nxt && !is_off
        |=> pick_r)
        else $error("pick-up released below reset ratio");
    chk_lpi_inhibit: assert property (lpi_r |-> !pick_r)
        else $error("pick-up while low power inhibit");
    chk_pickup_below: assert property (proc_r && lt_set && !lpi_nxt && !is_off |=> pick_r)
        else $error("no pick-up below setting");
    chk_mode_static: assert property (wr && addr != `REG_CTRL |=> ctrl_r == $past(ctrl_r))
        else $error("mode changed by other write");
    chk_start_unblk: assert property (proc_r && !is_off && st_r == underpower_pkg::ST_IDLE
        && pick_r && !blk_eff |=> st_r == underpower_pkg::ST_RUN ##2 start_o)
        else $error("start not raised");
    chk_blk_state: assert property (proc_r && !is_off && st_r == underpower_pkg::ST_IDLE
        && pick_r && blk_eff |=> st_r == underpower_pkg::ST_BLK ##2 blocked_o && !start_o)
        else $error("blocked pick-up mishandled");
    chk_block_drops: assert property (proc_r && !is_off && st_r == underpower_pkg::ST_RUN
        && blk_eff |=> st_r == underpower_pkg::ST_HOLD ##2 !start_o)
        else $error("start kept under block");
    chk_trip_expiry: assert property (proc_r && !is_off && st_r == underpower_pkg::ST_RUN
        && pick_r && !blk_eff && tmr_r == 16'h0 |=> act_t)
        else $error("no trip at delay expiry");
    chk_counter_inc: assert property (ev[2] |=> cnt[1] == $past(cnt[1]) + 16'h1)
        else $error("trip counter not advanced");
    chk_record_adv: assert property (rec_ev |=> rec_wp_r != $past(rec_wp_r))
        else $error("record pointer stuck");
    chk_force_cond: assert property (force_en && !w_ctrl |=> cond_o == $past(force_sel))
        else $error("forced condition not shown");
    cov_trip: cover property (act_t && !t_q);
    cov_blocked: cover property (act_b && !b_q);
    cov_hold_back: cover property (st_r == underpower_pkg::ST_HOLD ##1 st_r == underpower_pkg::ST_RUN);
    cov_rec_wrap: cover property (rec_ev && rec_wp_r == 4'(`NUM_RECORDS - 1));
endmodule

// file: meas_front_end.sv
// Measurement front end and blocking matrix model
module meas_front_end (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [14:0] cur_lvl,
    input wire logic [14:0] volt_lvl,
    input wire logic blk_req,
    output logic [14:0] cur_o,
    output logic [14:0] volt_o,
    output logic blk_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Levels refreshed every clock, zero in reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cur_o <= 15'h0000;
            volt_o <= 15'h0000;
            blk_o <= 1'b0;
        end else begin
            cur_o <= cur_lvl;
            volt_o <= volt_lvl;
            blk_o <= blk_req;
        end
    end
endmodule

// file: underpower_protection_stage_tb.sv
// Self-checking bench of the underpower stage
`include "underpower_params.svh"
module underpower_protection_stage_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 16;
    logic mclk, nrst, blk_req, block_in, wr, rd;
    logic [14:0] cur_lvl, volt_lvl, cur, volt;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    logic start_o, trip_o, blocked_o, irq_o, evt_valid_o;
    logic [1:0] cond_o;
    logic [2:0] evt_code_o;
    logic [31:0] evt_time;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int t0;
    int got_ev[8];
    int exp_ev[8];
    int exp_cnt[3];
    meas_front_end fe (.mclk(mclk), .nrst(nrst), .cur_lvl(cur_lvl), .volt_lvl(volt_lvl),
        .blk_req(blk_req), .cur_o(cur), .volt_o(volt), .blk_o(block_in));
    underpower_protection_stage #(.TICK_CYCLES(T)) dut (.mclk(mclk), .nrst(nrst),
        .phase_a_current_fundamental(cur), .phase_b_current_fundamental(cur),
        .phase_c_current_fundamental(cur), .voltage_ch1_fundamental(volt),
        .voltage_ch2_fundamental(volt), .voltage_ch3_fundamental(volt),
        .block_in(block_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .start_o(start_o), .trip_o(trip_o), .blocked_o(blocked_o), .cond_o(cond_o),
        .irq_o(irq_o), .evt_valid_o(evt_valid_o), .evt_code_o(evt_code_o),
        .evt_time_o(evt_time));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Event monitor and hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (evt_valid_o === 1'b1) begin
            got_ev[evt_code_o]++;
            checked++;
            if (evt_time > 32'(cyc / T) || evt_time + 32'h2 < 32'(cyc / T)) begin
                n_fail++;
                $display("[ERR] %0t event time %0d off", $time, evt_time);
            end
        end
        if (cyc == 20000) begin
            n_fail++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic ticks(input int n);
        repeat (n * T) @(posedge mclk);
        #1;
    endtask
    task automatic drive_i(input int v);
        @(posedge mclk);
        cur_lvl <= 15'(v);
    endtask
    task automatic wait_hi(input bit trip_sel);
        int c;
        c = 0;
        while ((trip_sel ? trip_o : start_o) !== 1'b1 && c < 20 * T) begin
            @(posedge mclk);
            #1 c++;
        end
    endtask
    initial begin
        nrst = 1'b0;
        blk_req = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h00000000;
        cur_lvl = 15'h0068;
        volt_lvl = 15'h0064;
        void'($urandom(32'h04F3));
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        rd_reg(`REG_CTRL, d); chk(d, `CTRL_RST, "ctrl reset");
        rd_reg(`REG_PSET, d); chk(d, `PSET_RST, "pset reset");
        rd_reg(`REG_OPDLY, d); chk(d, {16'h0000, `OPDLY_RST}, "opdly reset");
        rd_reg(8'hFC, d); chk(d, 32'h00000000, "unmapped read");
        // Setting 30000 makes ratio x100 equal the current level
        wr_reg(`REG_PSET, 32'h00007530);
        wr_reg(`REG_OPDLY, 32'h00000003);
        wr_reg(`REG_IRQ_EN, 32'h00000000);
        ticks(4);
        chk(start_o, 1'b0, "no pick above setting");
        t0 = 60 + $urandom % 30;
        drive_i(t0);
        wait_hi(1'b0);
        chk(start_o, 1'b1, "start on pick");
        chk(cond_o, 2'h1, "cond start");
        chk(irq_o, 1'b0, "irq masked");
        wr_reg(`REG_IRQ_EN, 32'h00000001);
        repeat (2) @(posedge mclk);
        #1 chk(irq_o, 1'b1, "irq raised");
        wr_reg(`REG_IRQ_CLR, 32'h00000001);
        repeat (2) @(posedge mclk);
        #1 chk(irq_o, 1'b0, "irq cleared");
        rd_reg(`REG_INFO, d); chk(d[31:16], 32'(t0), "ratio");
        rd_reg(`REG_TIMES, d); chk(d[15:0], 32'h3, "op time");
        wait_hi(1'b1);
        rd_reg(`REG_CNT_TRIP, d); chk(d, 32'h1, "trip count");
        chk(cond_o, 2'h2, "cond trip");
        exp_ev[0]++; exp_ev[2]++; exp_cnt[0]++; exp_cnt[1]++;
        drive_i(101);
        ticks(4);
        chk({start_o, trip_o}, 2'h3, "hysteresis hold");
        drive_i(104);
        ticks(4);
        chk({start_o, trip_o}, 2'h0, "release above 103");
        exp_ev[1]++; exp_ev[3]++;
        wr_reg(`REG_OPDLY, 32'h0000000A);
        drive_i(90);
        ticks(4);
        chk(start_o, 1'b1, "start before block");
        t0 = cyc;
        @(posedge mclk);
        blk_req <= 1'b1;
        ticks(4);
        chk(start_o, 1'b0, "late block drops start");
        chk({blocked_o, trip_o}, 2'h2, "blocked no trip");
        exp_ev[0]++; exp_ev[1]++; exp_ev[4]++; exp_cnt[0]++; exp_cnt[2]++;
        drive_i(104);
        @(posedge mclk);
        blk_req <= 1'b0;
        ticks(4);
        chk(blocked_o, 1'b0, "block off");
        exp_ev[5]++;
        for (int k = 0; k < 6; k++) chk(got_ev[k], exp_ev[k], "event count");
        rd_reg(`REG_REC_PTR, d); chk(d, 32'(exp_ev[0] + exp_ev[2] + exp_ev[4]), "rec ptr");
        wr_reg(`REG_REC_SEL, 32'h00000003);
        rd_reg(`REG_REC_FLT, d); chk(d, 32'(3 * 90 * 100), "record fault power");
        rd_reg(`REG_REC_INFO, d); chk(d[20:16], 32'h2, "record event");
        for (int k = 0; k < 3; k++) begin
            rd_reg(8'(`REG_CNT_START + 4 * k), d); chk(d, exp_cnt[k], "counter");
        end
        wr_reg(`REG_CNT_CLR, 32'h00000007);
        for (int k = 0; k < 3; k++) begin
            rd_reg(8'(`REG_CNT_START + 4 * k), d); chk(d, 32'h0, "counter clear");
        end
        wr_reg(`REG_OPDLY, 32'h00000002);
        wr_reg(`REG_CTRL, 32'h000001C0);
        drive_i(10);
        ticks(4);
        chk(start_o, 1'b0, "low power inhibit");
        drive_i(104);
        ticks(3);
        drive_i(90);
        ticks(4);
        chk(start_o, 1'b1, "inhibit released");
        drive_i(104);
        ticks(4);
        for (int m = 1; m < 5; m++) begin
            wr_reg(`REG_CTRL, 32'h000000C0 | m);
            drive_i(60 + $urandom % 30);
            ticks(6);
            chk(start_o, m == 2, "mode start");
            chk(trip_o, 1'b0, "mode trip");
            chk(blocked_o, m == 1 || m == 3, "mode blocked");
            drive_i(104);
            ticks(4);
        end
        for (int k = 0; k < 6; k++) exp_ev[k] = got_ev[k];
        wr_reg(`REG_OPDLY, 32'h0000000A);
        wr_reg(`REG_CTRL, 32'h00000040);
        drive_i(90);
        ticks(4);
        drive_i(104);
        ticks(4);
        exp_ev[0]++;
        for (int k = 0; k < 6; k++) chk(got_ev[k], exp_ev[k], "ON only storage");
        for (int f = 0; f < 4; f++) begin
            wr_reg(`REG_CTRL, 32'h000000C8 | (f << 4));
            repeat (3) @(posedge mclk);
            #1 chk(cond_o, f, "forced cond");
        end
        wr_reg(`REG_GROUP, 32'h00000001);
        rd_reg(`REG_CTRL, d); chk(d, 32'h000000F8, "ctrl static");
        drive_i(90);
        ticks(4);
        chk(start_o, 1'b0, "group 1 setting");
        complete_run();
    end
endmodule
